// ==== rtl/drive_cfg_pkg.sv ====
`default_nettype none
package drive_cfg_pkg;

	// Object dictionary indices and subindices
	localparam logic [15:0] IDX_DRIVE_FLAGS  = 16'h3212;
	localparam logic [15:0] IDX_ANALOG_IN    = 16'h3220;
	localparam logic [15:0] IDX_ANALOG_CTRL  = 16'h3221;
	localparam logic [7:0]  SUB_COUNT        = 8'h00;
	localparam logic [7:0]  SUB_SPARE        = 8'h01;
	localparam logic [7:0]  SUB_FIELD        = 8'h02;
	localparam logic [7:0]  SUB_KEEP         = 8'h03;
	localparam logic [7:0]  SUB_READING      = 8'h01;

	// Fixed counts and values after reset
	localparam logic [7:0]  DRIVE_FLAGS_COUNT  = 8'h03;
	localparam logic [7:0]  ANALOG_INPUT_COUNT = 8'h01;
	localparam logic [7:0]  FLAG_RESET         = 8'h00;
	localparam logic [1:0]  CTRL_RESET         = 2'h0;
	localparam logic [15:0] READING_RESET      = 16'h0000;

	// Field direction override and keep-gains encodings (signed 8 bit)
	localparam logic [7:0]  FIELD_DEFAULT  = 8'h00;
	localparam logic [7:0]  FIELD_POSITIVE = 8'h01;
	localparam logic [7:0]  FIELD_NEGATIVE = 8'hff;
	localparam logic [7:0]  GAINS_AUTO     = 8'h00;
	localparam logic [7:0]  GAINS_KEEP     = 8'h01;

	// Analog control word layout
	localparam int          CTRL_BIT_IN1   = 0;
	localparam int          CTRL_BIT_IN2   = 1;
	localparam int          CTRL_USED_BITS = 2;

	// Conversion scale: full scale digits map to 10 V or 20 mA
	localparam logic [15:0] ADC_FULL_SCALE_DIGITS = 16'h03ff;
	localparam int          VOLT_FULL_SCALE_MV    = 10000;
	localparam int          CURR_FULL_SCALE_UA    = 20000;

	typedef enum logic [2:0] {
		ENT_NONE,
		ENT_DF_COUNT,
		ENT_DF_SPARE,
		ENT_DF_FIELD,
		ENT_DF_KEEP,
		ENT_AI_COUNT,
		ENT_AI_READING,
		ENT_AI_CTRL
	} entry_e;

	function automatic entry_e decodeEntry(input logic [15:0] idx, input logic [7:0] sub);
		entry_e e;
		e = ENT_NONE;
		if (idx == IDX_DRIVE_FLAGS && sub == SUB_COUNT) e = ENT_DF_COUNT;
		if (idx == IDX_DRIVE_FLAGS && sub == SUB_SPARE) e = ENT_DF_SPARE;
		if (idx == IDX_DRIVE_FLAGS && sub == SUB_FIELD) e = ENT_DF_FIELD;
		if (idx == IDX_DRIVE_FLAGS && sub == SUB_KEEP) e = ENT_DF_KEEP;
		if (idx == IDX_ANALOG_IN && sub == SUB_COUNT) e = ENT_AI_COUNT;
		if (idx == IDX_ANALOG_IN && sub == SUB_READING) e = ENT_AI_READING;
		if (idx == IDX_ANALOG_CTRL && sub == SUB_COUNT) e = ENT_AI_CTRL;
		return e;
	endfunction

endpackage
`default_nettype wire

// ==== rtl/analog_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface analog_if;
	logic [1:0]  modeSel;
	logic [15:0] reading;
	logic        overRange;
	logic        selOne;
	logic        selTwo;
	modport ctrl (output modeSel, input reading, input overRange, input selOne, input selTwo);
	modport frontend (input modeSel, output reading, output overRange, output selOne, output selTwo);
endinterface
`default_nettype wire

// ==== rtl/analog_front_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module analog_front_end #(
	parameter logic [1:0] CURRENT_CAPABLE = 2'h1
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// Converter pins
	input  wire logic        adcValid,
	input  wire logic [15:0] adcData,
	// Toward the object block
	analog_if.frontend       ai
);
	logic [2:0]  validSync_q;
	logic [15:0] dataS1_q;
	logic [15:0] dataS2_q;
	logic [15:0] reading_q;
	logic        overRange_q;
	logic        selOne_q;
	logic        selTwo_q;

	// Data settles before the valid edge reaches stage two, so both paths use equal depth
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			validSync_q <= 3'h0;
			dataS1_q    <= 16'h0000;
			dataS2_q    <= 16'h0000;
		end else begin
			validSync_q <= {validSync_q[1:0], adcValid};
			dataS1_q    <= adcData;
			dataS2_q    <= dataS1_q;
		end
	end

	// R7: sample capture
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			reading_q   <= drive_cfg_pkg::READING_RESET;
			overRange_q <= 1'b0;
		end else if (validSync_q[1] && !validSync_q[2]) begin
			reading_q   <= dataS2_q;
			// R9 R10: full scale limit
			overRange_q <= $signed(dataS2_q) > $signed(drive_cfg_pkg::ADC_FULL_SCALE_DIGITS);
		end
	end

	// R12 R13: current mode gated
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			selOne_q <= 1'b0;
			selTwo_q <= 1'b0;
		end else begin
			selOne_q <= ai.modeSel[drive_cfg_pkg::CTRL_BIT_IN1] & CURRENT_CAPABLE[drive_cfg_pkg::CTRL_BIT_IN1];
			selTwo_q <= ai.modeSel[drive_cfg_pkg::CTRL_BIT_IN2] & CURRENT_CAPABLE[drive_cfg_pkg::CTRL_BIT_IN2];
		end
	end

	assign ai.reading   = reading_q;
	assign ai.overRange = overRange_q;
	assign ai.selOne    = selOne_q;
	assign ai.selTwo    = selTwo_q;

	selOneFollow_a: assert property (@(posedge sys_clk) disable iff (reset) // R12
		ai.modeSel[0] && CURRENT_CAPABLE[0] |=> selOne_q)
		else $error("Input one did not switch to current");
	noCurrentTwo_a: assert property (@(posedge sys_clk) disable iff (reset) // R13
		!CURRENT_CAPABLE[1] |-> !selTwo_q)
		else $error("Input two in current mode without support");
	sampleTaken_a: assert property (@(posedge sys_clk) disable iff (reset) // R7
		$rose(adcValid) ##2 (validSync_q[1] && !validSync_q[2]) |=> reading_q == $past(dataS2_q))
		else $error("Converter sample not captured");
	sampleCaptured_c: cover property (@(posedge sys_clk) disable iff (reset)
		validSync_q[1] && !validSync_q[2]);
endmodule
`default_nettype wire

// ==== rtl/drive_flags_analog_input_cfg.sv ====
// Notes on behaviour
// R1: Field override takes 0 default, 1 positive, -1 negative; others refused.
// R2: Field override write is stored, applied only at controller restart.
// R3: After changing field override and restarting, operator reruns auto setup.
// R4: Keep-gains 0: auto setup detects motor type, loads matching gain set.
// R5: Keep-gains 1: auto setup uses stored gains and leaves them unchanged.
// R6: Drive flags count reads 3; entries are signed 8 bit, reset zero.
// R7: Analog reading is read-only signed 16 bit in converter digits.
// R8: Analog count reads 1; the single reading resets to zero.
// R9: Voltage mode: 1023 digits equal 10 V, linear.
// R10: Current mode: 1023 digits equal 20 mA, linear.
// R11: Control bit 0 selects input one, bit 1 selects input two.
// R12: Control bit 0 means voltage, 1 means current.
// R13: Current mode only takes effect where hardware supports it.
// R14: Control bits 2 to 31 read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module drive_flags_analog_input_cfg #(
	parameter logic [1:0] CURRENT_CAPABLE = 2'h1
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// Object dictionary access
	input  wire logic        odReq,
	input  wire logic        odWrite,
	input  wire logic [15:0] odIndex,
	input  wire logic [7:0]  odSubindex,
	input  wire logic [31:0] odWdata,
	output logic             odAck,
	output logic             odAbort,
	output logic [31:0]      odRdata,
	// Drive control
	input  wire logic        controllerRestart,
	output logic             keepGains,
	output logic             forcePositiveField,
	output logic             forceNegativeField,
	// Analog input
	input  wire logic        adcValid,
	input  wire logic [15:0] adcData,
	output logic             input_one_measure_select,
	output logic             input_two_measure_select,
	output logic             adcOverRange
);
	analog_if ai ();

	drive_cfg_pkg::entry_e entry;
	logic        [7:0]  spare_q;
	logic        [7:0]  fieldStored_q;
	logic        [7:0]  keep_q;
	logic        [1:0]  ctrl_q;
	logic        [31:0] readMux;
	logic               writeOk;
	logic               ack_q;
	logic               abort_q;
	logic        [31:0] rdata_q;
	logic               keepGains_q;
	logic               forcePos_q;
	logic               forceNeg_q;
	logic        [7:0]  wByte;
	logic               fieldLegal;
	logic               keepLegal;

	assign entry = drive_cfg_pkg::decodeEntry(odIndex, odSubindex);
	assign wByte = odWdata[7:0];

	// R1: only three field values
	assign fieldLegal = wByte == drive_cfg_pkg::FIELD_DEFAULT || wByte == drive_cfg_pkg::FIELD_POSITIVE
		|| wByte == drive_cfg_pkg::FIELD_NEGATIVE;
	assign keepLegal = wByte == drive_cfg_pkg::GAINS_AUTO || wByte == drive_cfg_pkg::GAINS_KEEP;

	always_comb begin
		readMux = 32'h00000000;
		writeOk = 1'b0;
		unique case (entry)
			// R6: count is fixed
			drive_cfg_pkg::ENT_DF_COUNT: begin
				readMux = {24'h000000, drive_cfg_pkg::DRIVE_FLAGS_COUNT};
			end
			drive_cfg_pkg::ENT_DF_SPARE: begin
				readMux = {{24{spare_q[7]}}, spare_q};
				writeOk = 1'b1;
			end
			drive_cfg_pkg::ENT_DF_FIELD: begin
				readMux = {{24{fieldStored_q[7]}}, fieldStored_q};
				writeOk = fieldLegal;
			end
			drive_cfg_pkg::ENT_DF_KEEP: begin
				readMux = {{24{keep_q[7]}}, keep_q};
				writeOk = keepLegal;
			end
			// R8: one analog input
			drive_cfg_pkg::ENT_AI_COUNT: begin
				readMux = {24'h000000, drive_cfg_pkg::ANALOG_INPUT_COUNT};
			end
			// R7: signed reading, read only
			drive_cfg_pkg::ENT_AI_READING: begin
				readMux = {{16{ai.reading[15]}}, ai.reading};
			end
			// R14: upper bits zero
			drive_cfg_pkg::ENT_AI_CTRL: begin
				readMux = {30'h00000000, ctrl_q};
				writeOk = 1'b1;
			end
			drive_cfg_pkg::ENT_NONE: begin
				readMux = 32'h00000000;
			end
		endcase
	end

	// Answer one cycle after each request; unmapped, read-only or illegal writes abort
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ack_q   <= 1'b0;
			abort_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q   <= odReq;
			abort_q <= odReq && (entry == drive_cfg_pkg::ENT_NONE || (odWrite && !writeOk));
			rdata_q <= (odReq && !odWrite) ? readMux : 32'h00000000;
		end
	end

	// R6: entries reset to zero
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			spare_q       <= drive_cfg_pkg::FLAG_RESET;
			fieldStored_q <= drive_cfg_pkg::FLAG_RESET;
			keep_q        <= drive_cfg_pkg::FLAG_RESET;
		end else if (odReq && odWrite && writeOk) begin
			if (entry == drive_cfg_pkg::ENT_DF_SPARE) spare_q <= wByte;
			if (entry == drive_cfg_pkg::ENT_DF_FIELD) fieldStored_q <= wByte;
			if (entry == drive_cfg_pkg::ENT_DF_KEEP) keep_q <= wByte;
		end
	end

	// R11: control bits per input
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= drive_cfg_pkg::CTRL_RESET;
		end else if (odReq && odWrite && entry == drive_cfg_pkg::ENT_AI_CTRL) begin
			ctrl_q <= odWdata[drive_cfg_pkg::CTRL_USED_BITS-1:0];
		end
	end

	// R2: applied only at restart
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			forcePos_q    <= 1'b0;
			forceNeg_q    <= 1'b0;
		end else if (controllerRestart) begin
			forcePos_q    <= fieldStored_q == drive_cfg_pkg::FIELD_POSITIVE;
			forceNeg_q    <= fieldStored_q == drive_cfg_pkg::FIELD_NEGATIVE;
		end
	end

	// R4 R5: gain choice for setup
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			keepGains_q <= 1'b0;
		end else if (odReq && odWrite && writeOk && entry == drive_cfg_pkg::ENT_DF_KEEP) begin
			keepGains_q <= wByte == drive_cfg_pkg::GAINS_KEEP;
		end
	end

	assign ai.modeSel = ctrl_q;

	analog_front_end #(
		.CURRENT_CAPABLE(CURRENT_CAPABLE)
	) frontEnd (
		.sys_clk (sys_clk),
		.reset   (reset),
		.adcValid(adcValid),
		.adcData (adcData),
		.ai      (ai)
	);

	assign odAck                    = ack_q;
	assign odAbort                  = abort_q;
	assign odRdata                  = rdata_q;
	assign keepGains                = keepGains_q;
	assign forcePositiveField       = forcePos_q;
	assign forceNegativeField       = forceNeg_q;
	assign input_one_measure_select = ai.selOne;
	assign input_two_measure_select = ai.selTwo;
	assign adcOverRange             = ai.overRange;

	ackTiming_a: assert property (@(posedge sys_clk) disable iff (reset)
		odReq |=> odAck)
		else $error("Request not answered next cycle");
	badField_a: assert property (@(posedge sys_clk) disable iff (reset) // R1
		odReq && odWrite && entry == drive_cfg_pkg::ENT_DF_FIELD && !fieldLegal |=> odAbort && $stable(fieldStored_q))
		else $error("Illegal field value accepted");
	fieldHold_a: assert property (@(posedge sys_clk) disable iff (reset) // R2
		!controllerRestart |=> $stable(forcePositiveField) && $stable(forceNegativeField))
		else $error("Field direction changed without restart");
	restartLoad_a: assert property (@(posedge sys_clk) disable iff (reset) // R2
		controllerRestart && fieldStored_q == drive_cfg_pkg::FIELD_NEGATIVE |=> forceNegativeField && !forcePositiveField)
		else $error("Restart did not apply negative field");
	keepGains_a: assert property (@(posedge sys_clk) disable iff (reset) // R5
		odReq && odWrite && entry == drive_cfg_pkg::ENT_DF_KEEP && wByte == drive_cfg_pkg::GAINS_KEEP |=> keepGains)
		else $error("Keep gains not raised");
	autoGains_a: assert property (@(posedge sys_clk) disable iff (reset) // R4
		odReq && odWrite && entry == drive_cfg_pkg::ENT_DF_KEEP && wByte == drive_cfg_pkg::GAINS_AUTO |=> !keepGains)
		else $error("Keep gains not cleared");
	flagsCount_a: assert property (@(posedge sys_clk) disable iff (reset) // R6
		odReq && !odWrite && entry == drive_cfg_pkg::ENT_DF_COUNT |=> odRdata == 32'h00000003 && !odAbort)
		else $error("Drive flags count wrong");
	analogCount_a: assert property (@(posedge sys_clk) disable iff (reset) // R8
		odReq && !odWrite && entry == drive_cfg_pkg::ENT_AI_COUNT |=> odRdata == 32'h00000001)
		else $error("Analog count wrong");
	readingRo_a: assert property (@(posedge sys_clk) disable iff (reset) // R7
		odReq && odWrite && entry == drive_cfg_pkg::ENT_AI_READING |=> odAbort)
		else $error("Write to reading not refused");
	ctrlUpper_a: assert property (@(posedge sys_clk) disable iff (reset) // R14
		odReq && !odWrite && entry == drive_cfg_pkg::ENT_AI_CTRL |=> odRdata[31:2] == 30'h00000000)
		else $error("Control word upper bits not zero");

	restartApplied_c: cover property (@(posedge sys_clk) disable iff (reset)
		controllerRestart && fieldStored_q == drive_cfg_pkg::FIELD_POSITIVE);
	abortSeen_c: cover property (@(posedge sys_clk) disable iff (reset) odAbort);
	currentMode_c: cover property (@(posedge sys_clk) disable iff (reset) input_one_measure_select);
endmodule
`default_nettype wire

// ==== verification/drive_flags_analog_input_cfg_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module drive_flags_analog_input_cfg_tb;
	logic        sys_clk;
	logic        reset;
	logic        odReq;
	logic        odWrite;
	logic [15:0] odIndex;
	logic [7:0]  odSubindex;
	logic [31:0] odWdata;
	logic        odAck;
	logic        odAbort;
	logic [31:0] odRdata;
	logic        controllerRestart;
	logic        keepGains;
	logic        forcePositiveField;
	logic        forceNegativeField;
	logic        adcValid;
	logic [15:0] adcData;
	logic        input_one_measure_select;
	logic        input_two_measure_select;
	logic        adcOverRange;
	int          error_cnt;
	int          checks;

	drive_flags_analog_input_cfg #(.CURRENT_CAPABLE(2'h1)) drive_flags_analog_input_cfg_i (
		.sys_clk                  (sys_clk),
		.reset                    (reset),
		.odReq                    (odReq),
		.odWrite                  (odWrite),
		.odIndex                  (odIndex),
		.odSubindex               (odSubindex),
		.odWdata                  (odWdata),
		.odAck                    (odAck),
		.odAbort                  (odAbort),
		.odRdata                  (odRdata),
		.controllerRestart        (controllerRestart),
		.keepGains                (keepGains),
		.forcePositiveField       (forcePositiveField),
		.forceNegativeField       (forceNegativeField),
		.adcValid                 (adcValid),
		.adcData                  (adcData),
		.input_one_measure_select (input_one_measure_select),
		.input_two_measure_select (input_two_measure_select),
		.adcOverRange             (adcOverRange)
	);

	always #50 sys_clk = ~sys_clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t %s: seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// One access; the answer is sampled in the cycle after the request is taken
	task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
			output logic [31:0] rd, output logic ab);
		@(posedge sys_clk);
		odReq <= 1'b1;
		odWrite <= w;
		odIndex <= idx;
		odSubindex <= sub;
		odWdata <= wd;
		@(posedge sys_clk);
		odReq <= 1'b0;
		odWdata <= ~wd;
		#1;
		chk({31'h0, odAck}, 32'h1, "answer strobe");
		rd = odRdata;
		ab = odAbort;
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd, input logic expAb);
		logic [31:0] rd;
		logic        ab;
		acc(1'b1, idx, sub, wd, rd, ab);
		chk({31'h0, ab}, {31'h0, expAb}, "write refusal");
	endtask

	task automatic rdc(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
		logic [31:0] rd;
		logic        ab;
		acc(1'b0, idx, sub, 32'h0, rd, ab);
		chk({31'h0, ab}, 32'h0, "read refused");
		chk(rd, exp, "read data");
	endtask

	// Order: keepGains, forcePositiveField, forceNegativeField
	task automatic drv(input logic [2:0] exp);
		chk({29'h0, keepGains, forcePositiveField, forceNegativeField}, {29'h0, exp}, "drive outputs");
	endtask

	task automatic restart();
		@(posedge sys_clk);
		controllerRestart <= 1'b1;
		@(posedge sys_clk);
		controllerRestart <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic final_report();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic scen_reset();
		drv(3'h0);
		rdc(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_COUNT, 32'h3);
		for (int s = 1; s < 4; s++) begin
			rdc(drive_cfg_pkg::IDX_DRIVE_FLAGS, s[7:0], 32'h0);
		end
		rdc(drive_cfg_pkg::IDX_ANALOG_IN, drive_cfg_pkg::SUB_COUNT, 32'h1);
		rdc(drive_cfg_pkg::IDX_ANALOG_IN, drive_cfg_pkg::SUB_READING, 32'h0);
		rdc(drive_cfg_pkg::IDX_ANALOG_CTRL, drive_cfg_pkg::SUB_COUNT, 32'h0);
	endtask

	// override stored at once, applied only by restart
	task automatic scen_field();
		logic [7:0] vals [3] = '{8'hff, 8'h01, 8'h00};
		logic [2:0] outs [3] = '{3'h1, 3'h2, 3'h0};
		for (int i = 0; i < 3; i++) begin
			wr(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_FIELD, {24'h0, vals[i]}, 1'b0);
			rdc(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_FIELD, {{24{vals[i][7]}}, vals[i]});
			drv(i == 0 ? 3'h0 : outs[i - 1]);
			restart();
			drv(outs[i]);
		end
		wr(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_FIELD, 32'h02, 1'b1);
		rdc(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_FIELD, 32'h0);
		wr(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_SPARE, 32'h80, 1'b0);
		rdc(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_SPARE, 32'hffffff80);
	endtask

	// keep-gains selection, only 0 and 1 taken
	task automatic scen_gains();
		wr(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_KEEP, 32'h1, 1'b0);
		@(posedge sys_clk);
		#1;
		drv(3'h4);
		wr(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_KEEP, 32'h2, 1'b1);
		rdc(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_KEEP, 32'h1);
		wr(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_KEEP, 32'h0, 1'b0);
		@(posedge sys_clk);
		#1;
		drv(3'h0);
	endtask

	// read-only and unmapped entries refuse writes
	task automatic scen_refuse();
		wr(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_COUNT, 32'h7, 1'b1);
		wr(drive_cfg_pkg::IDX_ANALOG_IN, drive_cfg_pkg::SUB_COUNT, 32'h7, 1'b1);
		wr(drive_cfg_pkg::IDX_ANALOG_IN, drive_cfg_pkg::SUB_READING, 32'h7, 1'b1);
		wr(16'h3213, 8'h00, 32'h7, 1'b1);
		rdc(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_COUNT, 32'h3);
	endtask

	// measurement selects; only input one can do current here
	task automatic scen_ctrl();
		logic [31:0] wv [3] = '{32'hffffffff, 32'h2, 32'h0};
		logic [1:0]  sv [3] = '{2'h1, 2'h0, 2'h0};
		logic [31:0] rd;
		logic        ab;
		for (int i = 0; i < 3; i++) begin
			wr(drive_cfg_pkg::IDX_ANALOG_CTRL, drive_cfg_pkg::SUB_COUNT, wv[i], 1'b0);
			@(posedge sys_clk);
			#1;
			chk({30'h0, input_two_measure_select, input_one_measure_select}, {30'h0, sv[i]}, "select");
			acc(1'b0, drive_cfg_pkg::IDX_ANALOG_CTRL, drive_cfg_pkg::SUB_COUNT, 32'h0, rd, ab);
			chk(rd, wv[i] & 32'h3, "control readback");
		end
	endtask

	// signed converter reading, sign-extended on read
	task automatic scen_adc(input logic [15:0] v, input logic ovr);
		@(posedge sys_clk);
		adcData <= v;
		@(posedge sys_clk);
		adcValid <= 1'b1;
		repeat (6) @(posedge sys_clk);
		adcValid <= 1'b0;
		adcData <= ~v;
		rdc(drive_cfg_pkg::IDX_ANALOG_IN, drive_cfg_pkg::SUB_READING, {{16{v[15]}}, v});
		chk({31'h0, adcOverRange}, {31'h0, ovr}, "over range");
	endtask

	initial begin
		sys_clk = 1'b0;
		reset = 1'b1;
		odReq = 1'b0;
		odWrite = 1'b0;
		odIndex = 16'h0;
		odSubindex = 8'h0;
		odWdata = 32'h0;
		controllerRestart = 1'b0;
		adcValid = 1'b0;
		adcData = 16'h0;
		error_cnt = 0;
		checks = 0;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		scen_reset();
		scen_field();
		scen_gains();
		scen_refuse();
		scen_ctrl();
		scen_adc(16'h8001, 1'b0);
		scen_adc(16'h0400, 1'b1);
		wr(drive_cfg_pkg::IDX_ANALOG_CTRL, drive_cfg_pkg::SUB_COUNT, 32'h1, 1'b0);
		scen_adc(16'h03ff, 1'b0);
		chk({31'h0, input_one_measure_select}, 32'h1, "current mode");
		chk({31'h0, adcOverRange}, 32'h0, "current full scale");
		final_report();
	end

	// Guard against a hung run
	initial begin
		#2ms;
		error_cnt++;
		final_report();
	end
endmodule
`default_nettype wire
